// ===== sim/shb_far_codec_model.sv
// Far codec model: sends link transfers, sinks transmit characters.
// Assumes the bench calls send() and drives stall.
`timescale 1ns/1ps

module shb_far_codec_model import shb_pkg::*; (
	// Clock
	input  wire logic      core_clk,
	// Link toward the block
	output shb_link_xfer_s linkXfer,
	output logic           linkXferValid,
	input  wire logic      linkReady_reg,
	input  wire logic      linkErrorResponse_reg,
	// Characters from the block
	input  wire logic      txCharValid_reg,
	input  wire shb_char_s txChar_reg,
	output logic           txCharReady,
	input  wire logic      stall
);
	shb_char_s sinkQ[$];
	logic      linkUp;

	initial begin
		linkXfer = '0;
		linkXferValid = 1'b0;
		txCharReady = 1'b0;
		linkUp = 1'b1;
	end

	always @(posedge core_clk) begin
		txCharReady <= !stall;
		if (txCharValid_reg && txCharReady)
			sinkQ.push_back(txChar_reg);
	end

	always @(posedge core_clk) begin
		if (linkErrorResponse_reg)
			linkUp <= 1'b0;
		else
			linkUp <= 1'b1;
	end

	task automatic send(input shb_link_xfer_s x);
		int n;
		n = 0;
		@(posedge core_clk);
		// hold off while our link restarts after an error
		while ((!linkReady_reg || !linkUp || linkErrorResponse_reg)
			&& n < 100) begin
			n++;
			@(posedge core_clk);
		end
		linkXferValid <= 1'b1;
		linkXfer      <= x;
		@(posedge core_clk);
		linkXferValid <= 1'b0;
		// Released lines must not keep the old value
		linkXfer      <= ~x;
	endtask : send
endmodule : shb_far_codec_model

// ===== sim/tb_spacewire_host_buffers_rx_check.sv
// Self-checking bench for the host buffers block.
// Assumes the far codec model sits on the link and encoder ports.
`timescale 1ns/1ps
`include "shb_consts.svh"

module tb_spacewire_host_buffers_rx_check import shb_pkg::*;;
	localparam logic [7:0] A_TTC = 8'h28;
	logic core_clk, reset_n, hostReqValid, stall;
	shb_host_req_s hostReq;
	logic respV, cmdErr, txV, tcStrobe, ready, lResp, lErr, reinit, fatal;
	logic [15:0] rdata;
	shb_char_s txChar;
	logic [7:0] txTc;
	logic txReady, xV, d0;
	shb_link_xfer_s xfer;
	int failures, checked, i, n;
	logic [15:0] d;
	logic e;
	logic [8:0] refTab[8];

	shb_host_buffers #(.ADDR_TX_TCODE(A_TTC)) dut_u (
		.core_clk(core_clk), .reset_n(reset_n),
		.hostReqValid(hostReqValid), .hostReq(hostReq),
		.hostRespValid_reg(respV), .commandErrorResponse_reg(cmdErr),
		.hostRdata_reg(rdata), .txCharValid_reg(txV),
		.txChar_reg(txChar), .txCharReady(txReady),
		.txTimeCode_reg(txTc), .txTimeCodeStrobe_reg(tcStrobe),
		.linkXferValid(xV), .linkXfer(xfer), .linkReady_reg(ready),
		.linkRespValid_reg(lResp), .linkErrorResponse_reg(lErr),
		.linkReinit_reg(reinit), .fatalError_reg(fatal));

	shb_far_codec_model far_u (
		.core_clk(core_clk), .linkXfer(xfer), .linkXferValid(xV),
		.linkReady_reg(ready), .linkErrorResponse_reg(lErr),
		.txCharValid_reg(txV), .txChar_reg(txChar),
		.txCharReady(txReady), .stall(stall));

	always #5 core_clk = ~core_clk;

	task automatic chk(input string nm, input logic [15:0] exp, got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One host request, answer registered on the take edge itself
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [15:0] wd);
		@(posedge core_clk);
		hostReqValid <= 1'b1;
		hostReq      <= '{write: w, addr: a, wdata: wd};
		@(posedge core_clk);
		hostReqValid <= 1'b0;
		#1;
		chk("hostResp", 16'h0001, {15'h0000, respV});
		d = rdata;
		e = cmdErr;
	endtask : acc

	function automatic shb_link_xfer_s mk(input logic [7:0] f, v,
		input logic er, tc, input logic [7:0] len);
		mk = '0;
		mk.bitClkPeriod = 16'h0064;
		mk.length = len;
		mk.parityPresent = 1'b1;
		mk.flagPresent = 1'b1;
		mk.errorInjected = er;
		mk.isTimeCode = tc;
		mk.chr = '{value: v, flag: f};
	endfunction : mk

	task automatic lsend(input shb_link_xfer_s x, input logic [15:0] ex);
		far_u.send(x);
		@(posedge core_clk);
		#1;
		chk("linkResp", ex, {13'h0000, lResp, lErr, reinit});
	endtask : lsend

	task automatic end_sim;
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	initial begin
		#200000;
		failures++;
		end_sim();
	end

	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		hostReqValid = 1'b0;
		hostReq = '0;
		stall = 1'b1;
		failures = 0;
		checked = 0;
		refTab = '{9'h114, 9'h118, 9'h11C, 9'h120, 9'h010, {1'b0, A_TTC},
			9'h124, 9'h018};
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		acc(1'b0, `SHB_ADDR_RX_EMPTY, 16'h0000);
		chk("rxEmpty", 16'h0001, d);
		acc(1'b0, `SHB_ADDR_RX_TCODE, 16'h0000);
		chk("rxTcode", 16'h0000, d);
		// Wrong direction, moved address, empty read
		for (i = 0; i < 8; i++) begin
			acc(refTab[i][8], refTab[i][7:0], 16'hFFFF);
			chk("refused", 16'h0001, {d[14:0], e});
		end
		n = 0;
		for (i = 0; i < 20; i++) begin
			acc(1'b0, `SHB_ADDR_TX_FULL, 16'h0000);
			d0 = d[0];
			if (d0)
				break;
			acc(1'b1, `SHB_ADDR_TX_FIFO, {i[7:0], 7'h00, i[0]});
			n++;
		end
		// FIFO entries plus the one held in the output stage
		chk("fullAt", 16'h0001, {15'h0000, n == `SHB_FIFO_DEPTH + 1});
		acc(1'b1, `SHB_ADDR_TX_FIFO, 16'hAA00);
		chk("fullWrite", 16'h0001, {15'h0000, e});
		stall <= 1'b0;
		repeat (40) @(posedge core_clk);
		chk("txCount", n[15:0], far_u.sinkQ.size());
		for (i = 0; i < n; i++)
			chk("txChar", {i[7:0], 7'h00, i[0]}, far_u.sinkQ[i]);
		acc(1'b1, A_TTC, 16'h005A);
		chk("txTcode", 16'h015A, {7'h00, tcStrobe, txTc});
		lsend(mk(8'h00, 8'h33, 1'b0, 1'b0, 8'h01), 16'h0004);
		acc(1'b0, `SHB_ADDR_RX_EMPTY, 16'h0000);
		chk("rxEmpty", 16'h0000, d);
		acc(1'b0, `SHB_ADDR_RX_BUF, 16'h0000);
		chk("rxChar", 16'h3300, d);
		lsend(mk(8'h00, 8'h7C, 1'b0, 1'b1, 8'h01), 16'h0004);
		acc(1'b0, `SHB_ADDR_RX_TCODE, 16'h0000);
		chk("rxTcode", 16'h007C, d);
		lsend(mk(8'h00, 8'h44, 1'b1, 1'b0, 8'h01), 16'h0007);
		lsend(mk(8'h01, 8'h00, 1'b0, 1'b0, 8'h01), 16'h0004);
		acc(1'b0, `SHB_ADDR_RX_BUF, 16'h0000);
		chk("errChar", 16'h4400, d);
		acc(1'b0, `SHB_ADDR_RX_BUF, 16'h0000);
		chk("errEnd", 16'h0101, d);
		acc(1'b0, `SHB_ADDR_RX_EMPTY, 16'h0000);
		chk("rxEmpty", 16'h0001, d);
		lsend(mk(8'h00, 8'h55, 1'b0, 1'b0, 8'h00), 16'h0000);
		chk("fatal", 16'h0001, {15'h0000, fatal});
		// Mid-run reset clears the sticky fatal flag
		@(posedge core_clk);
		reset_n <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("resetOut", 16'h0000, {14'h0000, fatal, ready});
		@(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk("linkReady", 16'h0001, {15'h0000, ready});
		end_sim();
	end
endmodule : tb_spacewire_host_buffers_rx_check

// ===== src/shb_consts.svh
// Constants for the host buffers and link receive check block.
// Assumes a 16-bit host data path and one link character per transfer.
`ifndef SHB_CONSTS_SVH
`define SHB_CONSTS_SVH

// Default host addresses, overridable per instance
`define SHB_ADDR_TX_FIFO   8'h10
`define SHB_ADDR_TX_FULL   8'h14
`define SHB_ADDR_RX_BUF    8'h18
`define SHB_ADDR_RX_EMPTY  8'h1C
`define SHB_ADDR_RX_TCODE  8'h20
`define SHB_ADDR_TX_TCODE  8'h24

// Character layout: byte 0 is the flag, byte 1 the value
`define SHB_CHAR_FLAG_LSB  0
`define SHB_CHAR_VALUE_LSB 8
`define SHB_FLAG_DATA      8'h00
`define SHB_FLAG_CTRL      8'h01
`define SHB_VALUE_EOP      8'h00
`define SHB_VALUE_EEP      8'h01

// Sizes and reset values
`define SHB_FIFO_DEPTH     16
`define SHB_CHAR_WIDTH     16
`define SHB_TCODE_RESET    8'h00
`define SHB_RX_READY_SLACK 3

`endif

// ===== src/shb_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
// Assumes one clock; full means occupancy equals DEPTH.
`timescale 1ns/1ps
`include "shb_consts.svh"

module shb_fifo import shb_pkg::*; #(
	parameter int WIDTH = `SHB_CHAR_WIDTH,
	parameter int DEPTH = `SHB_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	// Fill side
	input  wire logic                       inValid,
	input  wire logic [WIDTH-1:0]           inData,
	output logic                            inReady,
	// Drain side
	output logic                            outValid,
	output logic [WIDTH-1:0]                outData,
	input  wire logic                       outReady,
	// Occupancy
	output logic [$clog2(DEPTH+1)-1:0]      count
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [$clog2(DEPTH+1)-1:0] count_reg;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign inReady  = (count_reg != ($clog2(DEPTH+1))'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign count    = count_reg;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) wrPtr_reg <= bump(wrPtr_reg);
			if (pop) rdPtr_reg <= bump(rdPtr_reg);
			count_reg <= count_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end

endmodule : shb_fifo

// ===== src/shb_host_buffers.sv
// Host buffers of a link codec: transmit FIFO, receive buffer, time codes,
// and checking of incoming link transfers.
// Assumes host requests and link transfers are synchronous to core_clk.
//
// What this block does
// - Transmit entry is two bytes: flag in byte 0, value in byte 1.
// - Transmit FIFO depth and width are parameters.
// - Transmit data is write-only; full flag is a separate read-only address.
// - Write when full is discarded with a command error response.
// - Receive buffer depth and width are parameters.
// - Receive buffer and empty flag are read-only, each at own address.
// - Read when empty is not performed; command error response returned.
// - All six host addresses are parameters.
// - Read-only received and write-only transmit time codes, 8 bits each.
// - Link transfers are single phase; no acknowledge per sent character.
// - Data characters interleave with null, flow control and time codes.
// - Zero clock period, zero length, missing parity or flag: fatal error.
// - Exchange level: disconnection checked first, error response and link reinitialisation, nothing stored.
// - Receive error returns error response and starts link reinitialisation.
// - Packet level: errored packet stored, its end marker becomes error end.
`timescale 1ns/1ps
`include "shb_consts.svh"

module shb_host_buffers import shb_pkg::*; #(
	parameter int         TX_DEPTH     = `SHB_FIFO_DEPTH,
	parameter int         TX_WIDTH     = `SHB_CHAR_WIDTH,
	parameter int         RX_DEPTH     = `SHB_FIFO_DEPTH,
	parameter int         RX_WIDTH     = `SHB_CHAR_WIDTH,
	parameter bit         PACKET_LEVEL = 1'b1,
	parameter logic [7:0] ADDR_TX_FIFO  = `SHB_ADDR_TX_FIFO,
	parameter logic [7:0] ADDR_TX_FULL  = `SHB_ADDR_TX_FULL,
	parameter logic [7:0] ADDR_RX_BUF   = `SHB_ADDR_RX_BUF,
	parameter logic [7:0] ADDR_RX_EMPTY = `SHB_ADDR_RX_EMPTY,
	parameter logic [7:0] ADDR_RX_TCODE = `SHB_ADDR_RX_TCODE,
	parameter logic [7:0] ADDR_TX_TCODE = `SHB_ADDR_TX_TCODE
) (
	// Clock and reset
	input  wire logic           core_clk,
	input  wire logic           reset_n,
	// Host request port
	input  wire logic           hostReqValid,
	input  wire shb_host_req_s  hostReq,
	// Host response port
	output logic                hostRespValid_reg,
	output logic                commandErrorResponse_reg,
	output logic [15:0]         hostRdata_reg,
	// Characters toward the transmit encoder
	output logic                txCharValid_reg,
	output shb_char_s           txChar_reg,
	input  wire logic           txCharReady,
	// Time code toward the transmit encoder
	output logic [7:0]          txTimeCode_reg,
	output logic                txTimeCodeStrobe_reg,
	// Transfers from the far codec via the receive decoder
	input  wire logic           linkXferValid,
	input  wire shb_link_xfer_s linkXfer,
	output logic                linkReady_reg,
	// Link response and error outputs
	output logic                linkRespValid_reg,
	output logic                linkErrorResponse_reg,
	output logic                linkReinit_reg,
	output logic                fatalError_reg
);

	//------------------------------------------------------------
	// Host address decode
	//------------------------------------------------------------
	localparam int TXC = $clog2(TX_DEPTH + 1);
	localparam int RXC = $clog2(RX_DEPTH + 1);

	logic hitTxFifo;
	logic hitTxFull;
	logic hitRxBuf;
	logic hitRxEmpty;
	logic hitRxTcode;
	logic hitTxTcode;
	logic wr;
	logic [7:0] rxTimeCode_reg;

	function automatic logic isEop(input shb_char_s c);
		return c.flag == `SHB_FLAG_CTRL && c.value == `SHB_VALUE_EOP;
	endfunction : isEop

	assign hitTxFifo  = hostReq.addr == ADDR_TX_FIFO;
	assign hitTxFull  = hostReq.addr == ADDR_TX_FULL;
	assign hitRxBuf   = hostReq.addr == ADDR_RX_BUF;
	assign hitRxEmpty = hostReq.addr == ADDR_RX_EMPTY;
	assign hitRxTcode = hostReq.addr == ADDR_RX_TCODE;
	assign hitTxTcode = hostReq.addr == ADDR_TX_TCODE;
	assign wr         = hostReq.write;

	//------------------------------------------------------------
	// Transmit FIFO
	//------------------------------------------------------------
	logic                txPush;
	logic                txInReady;
	logic                txOutValid;
	logic [TX_WIDTH-1:0] txOutData;
	logic                txPop;
	logic [TXC-1:0]      txCount;

	assign txPush = hostReqValid && wr && hitTxFifo && txInReady;
	assign txPop  = txOutValid && (!txCharValid_reg || txCharReady);

	shb_fifo #(
		.WIDTH (TX_WIDTH),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.inValid  (txPush),
		.inData   (TX_WIDTH'(hostReq.wdata)),
		.inReady  (txInReady),
		.outValid (txOutValid),
		.outData  (txOutData),
		.outReady (txPop),
		.count    (txCount)
	);

	// Output stage so the encoder sees flops; it stalls the FIFO
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			txCharValid_reg <= 1'b0;
			txChar_reg      <= '0;
		end else if (!txCharValid_reg || txCharReady) begin
			txCharValid_reg <= txOutValid;
			// byte 0 flag, byte 1 value
			txChar_reg.flag  <= txOutData[`SHB_CHAR_FLAG_LSB +: 8];
			txChar_reg.value <= txOutData[`SHB_CHAR_VALUE_LSB +: 8];
		end
	end

	//------------------------------------------------------------
	// Receive buffer
	//------------------------------------------------------------
	logic                rxPush;
	logic [RX_WIDTH-1:0] rxPushData;
	logic                rxInReady;
	logic                rxOutValid;
	logic [RX_WIDTH-1:0] rxOutData;
	logic                rxPop;
	logic [RXC-1:0]      rxCount;

	// pop only when a word is held
	assign rxPop = hostReqValid && !wr && hitRxBuf && rxOutValid;

	shb_fifo #(
		.WIDTH (RX_WIDTH),
		.DEPTH (RX_DEPTH)
	) u_rx_buf (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.inValid  (rxPush),
		.inData   (rxPushData),
		.inReady  (rxInReady),
		.outValid (rxOutValid),
		.outData  (rxOutData),
		.outReady (rxPop),
		.count    (rxCount)
	);

	//------------------------------------------------------------
	// Host response
	//------------------------------------------------------------
	logic        respErr_next;
	logic [15:0] rdata_next;

	always_comb begin
		respErr_next = 1'b0;
		rdata_next   = '0;
		if (wr) begin
			if (hitTxFifo) begin
				respErr_next = !txInReady;
			end else if (!hitTxTcode) begin
				respErr_next = 1'b1;
			end
		end else if (hitTxFull) begin
			rdata_next = {15'h0000, !txInReady};
		end else if (hitRxEmpty) begin
			rdata_next = {15'h0000, !rxOutValid};
		end else if (hitRxBuf) begin
			respErr_next = !rxOutValid;
			rdata_next   = rxOutValid ? 16'(rxOutData) : 16'h0000;
		end else if (hitRxTcode) begin
			rdata_next = {8'h00, rxTimeCode_reg};
		end else begin
			respErr_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hostRespValid_reg        <= 1'b0;
			commandErrorResponse_reg <= 1'b0;
			hostRdata_reg            <= '0;
		end else begin
			hostRespValid_reg        <= hostReqValid;
			commandErrorResponse_reg <= hostReqValid && respErr_next;
			hostRdata_reg            <= hostReqValid ? rdata_next : 16'h0000;
		end
	end

	//------------------------------------------------------------
	// Time codes
	//------------------------------------------------------------

	// strobe lets the encoder interleave it with characters
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			txTimeCode_reg       <= `SHB_TCODE_RESET;
			txTimeCodeStrobe_reg <= 1'b0;
		end else begin
			txTimeCodeStrobe_reg <= hostReqValid && wr && hitTxTcode;
			if (hostReqValid && wr && hitTxTcode) begin
				txTimeCode_reg <= hostReq.wdata[7:0];
			end
		end
	end

	//------------------------------------------------------------
	// Link transfer check and storage
	//------------------------------------------------------------
	logic           vValid;
	shb_verdict_e   verdict;
	shb_link_xfer_s vXfer;
	logic           pktErr_reg;
	logic           storeChar;
	logic           markEep;

	shb_link_check #(
		.PACKET_LEVEL (PACKET_LEVEL)
	) u_link_check (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.xferValid    (linkXferValid && linkReady_reg),
		.xfer         (linkXfer),
		.verdictValid (vValid),
		.verdict      (verdict),
		.xferOut      (vXfer)
	);

	// errored characters still stored at packet level
	assign storeChar = vValid && !vXfer.isTimeCode &&
		(verdict == VERDICT_OK ||
		 (PACKET_LEVEL && verdict == VERDICT_ERROR));
	assign markEep = PACKET_LEVEL && isEop(vXfer.chr) &&
		(pktErr_reg || verdict == VERDICT_ERROR);
	assign rxPush = storeChar && rxInReady;
	// end marker replaced by error end
	assign rxPushData = RX_WIDTH'({markEep ? `SHB_VALUE_EEP : vXfer.chr.value,
		vXfer.chr.flag});

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pktErr_reg <= 1'b0;
		end else if (rxPush && isEop(vXfer.chr)) begin
			pktErr_reg <= 1'b0;
		end else if (vValid && verdict == VERDICT_ERROR) begin
			pktErr_reg <= 1'b1;
		end
	end

	// Margin covers the transfer in flight and the check stage
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			linkReady_reg <= 1'b0;
		end else begin
			linkReady_reg <= (32'(rxCount) + `SHB_RX_READY_SLACK) <= RX_DEPTH;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxTimeCode_reg <= `SHB_TCODE_RESET;
		end else if (vValid && vXfer.isTimeCode && verdict == VERDICT_OK) begin
			rxTimeCode_reg <= vXfer.chr.value;
		end
	end

	// one response per transfer except invalid ones, single phase
	// sender resets on the error response
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			linkRespValid_reg     <= 1'b0;
			linkErrorResponse_reg <= 1'b0;
			linkReinit_reg        <= 1'b0;
		end else begin
			linkRespValid_reg     <= vValid && verdict != VERDICT_INVALID;
			linkErrorResponse_reg <= vValid &&
				(verdict == VERDICT_DISC || verdict == VERDICT_ERROR);
			linkReinit_reg        <= vValid &&
				(verdict == VERDICT_DISC || verdict == VERDICT_ERROR);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fatalError_reg <= 1'b0;
		end else if (vValid && verdict == VERDICT_INVALID) begin
			fatalError_reg <= 1'b1;
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_tx_full_drop: assert property (
		hostReqValid && wr && hitTxFifo && !txInReady && !txPop
		|=> commandErrorResponse_reg && $stable(txCount))
		else $error("write to full transmit FIFO not refused");
	a_rx_empty_read: assert property (
		hostReqValid && !wr && hitRxBuf && !rxOutValid
		|=> commandErrorResponse_reg && hostRdata_reg == 16'h0000)
		else $error("read of empty receive buffer not refused");
	a_ro_write: assert property (
		hostReqValid && wr && (hitTxFull || hitRxBuf || hitRxEmpty)
		|=> hostRespValid_reg && commandErrorResponse_reg)
		else $error("write to read-only location accepted");
	a_full_flag: assert property (
		hostReqValid && !wr && hitTxFull
		|=> hostRdata_reg[0] == ($past(txCount) == TXC'(TX_DEPTH)))
		else $error("full flag does not match occupancy");
	a_tcode_write: assert property (
		hostReqValid && wr && hitTxTcode
		|=> txTimeCodeStrobe_reg && !commandErrorResponse_reg
		&& txTimeCode_reg == $past(hostReq.wdata[7:0]))
		else $error("time code write not taken");
	a_link_single: assert property (
		linkXferValid && linkReady_reg && linkXfer.bitClkPeriod != '0
		&& linkXfer.length != '0 && linkXfer.parityPresent
		&& linkXfer.flagPresent |-> ##2 linkRespValid_reg)
		else $error("link transfer without its single response");
	a_invalid_fatal: assert property (
		vValid && verdict == VERDICT_INVALID
		|=> fatalError_reg && !linkRespValid_reg)
		else $error("invalid transfer not fatal");
	a_disc_first: assert property (
		vValid && verdict == VERDICT_DISC
		|-> !rxPush ##1 linkErrorResponse_reg && linkReinit_reg)
		else $error("disconnection not answered with error only");
	a_err_reinit: assert property (
		vValid && verdict == VERDICT_ERROR
		|=> linkRespValid_reg && linkErrorResponse_reg && linkReinit_reg)
		else $error("receive error without reinitialisation");
	a_eep_mark: assert property (
		rxPush && PACKET_LEVEL && isEop(vXfer.chr) && pktErr_reg
		|-> rxPushData[`SHB_CHAR_VALUE_LSB +: 8] == `SHB_VALUE_EEP)
		else $error("errored packet kept its normal end marker");

	c_tx_full: cover property (hostReqValid && wr && hitTxFifo && !txInReady);
	c_rx_read: cover property (rxPop ##1 hostRespValid_reg);
	c_eep: cover property (rxPush && markEep);
	c_err_resp: cover property (linkErrorResponse_reg);

endmodule : shb_host_buffers

// ===== src/shb_link_check.sv
// Registered classification of one incoming link transfer.
// Assumes the transfer is presented for one cycle with its valid.
`timescale 1ns/1ps
`include "shb_consts.svh"

module shb_link_check import shb_pkg::*; #(
	parameter bit PACKET_LEVEL = 1'b1
) (
	// Clock and reset
	input  wire logic           core_clk,
	input  wire logic           reset_n,
	// Incoming transfer
	input  wire logic           xferValid,
	input  wire shb_link_xfer_s xfer,
	// Verdict, one cycle later
	output logic                verdictValid,
	output shb_verdict_e        verdict,
	output shb_link_xfer_s      xferOut
);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			verdictValid <= 1'b0;
			verdict      <= VERDICT_OK;
			xferOut      <= '0;
		end else begin
			verdictValid <= xferValid;
			xferOut      <= xfer;
			if (xfer.bitClkPeriod == '0 || xfer.length == '0 ||
			    !xfer.parityPresent || !xfer.flagPresent) begin
				verdict <= VERDICT_INVALID;
			end else if (!PACKET_LEVEL && xfer.disconnectErr) begin
				verdict <= VERDICT_DISC;
			end else if (PACKET_LEVEL ? xfer.errorInjected : xfer.rxError) begin
				verdict <= VERDICT_ERROR;
			end else begin
				verdict <= VERDICT_OK;
			end
		end
	end

endmodule : shb_link_check

// ===== src/shb_pkg.sv
// Types shared by the host buffers block and its submodules.
// Assumes the constants header is included by the modules themselves.
package shb_pkg;

	typedef struct packed {
		logic [7:0] value;
		logic [7:0] flag;
	} shb_char_s;

	typedef struct packed {
		logic       write;
		logic [7:0] addr;
		logic [15:0] wdata;
	} shb_host_req_s;

	typedef struct packed {
		logic [15:0] bitClkPeriod;
		logic [7:0]  length;
		logic        parityPresent;
		logic        flagPresent;
		logic        disconnectErr;
		logic        errorInjected;
		logic        rxError;
		logic        isTimeCode;
		shb_char_s   chr;
	} shb_link_xfer_s;

	typedef enum logic [3:0] {
		VERDICT_OK      = 4'b0001,
		VERDICT_INVALID = 4'b0010,
		VERDICT_DISC    = 4'b0100,
		VERDICT_ERROR   = 4'b1000
	} shb_verdict_e;

endpackage : shb_pkg
